// [core/ocs_clock_select.v]
// oscillator clock-source selection and clock-rate enable generation
// Operation
// - provide quad-rate and half-rate clock outputs
// - bus clock is quad-rate divided by four
// - four sources, internal oscillator after reset unless the configuration selects another
// - select bits choose source per encoding
// - configuration register bits have defined defaults
// - wait mode leaves clocks running
// - stop mode halts selected source and clocks
// - break state keeps clocks running
`timescale 1ns/10ps
`include "ocs_consts.vh"
module ocs_clock_select
(
    // clock and reset
    input  wire                        clk_sys_i,
    input  wire                        rst_i,
    // configuration
    input  wire                        cfg2_valid_i,
    input  wire [`OCS_CFG2_WIDTH-1:0]  cfg2_value_i,
    // source clock level inputs (pins and oscillators)
    input  wire                        internal_source_clock_i,
    input  wire                        external_clock_pin_i,
    input  wire                        rc_source_clock_i,
    input  wire                        crystal_source_clock_i,
    // power modes
    input  wire                        wait_mode_i,
    input  wire                        stop_mode_i,
    input  wire                        break_state_i,
    // outputs
    output reg                         quad_rate_clock_o,
    output reg                         half_rate_clock_o,
    output reg                         bus_clock_en_o,
    output reg  [1:0]                  source_sel_o,
    output reg                         source_run_o
);
    // =====================================================
    // source inputs synchronised one lane at a time; they are sampled as levels
    wire [3:0] src_raw;
    wire [3:0] src_sync;

    assign src_raw = {crystal_source_clock_i, rc_source_clock_i,
                      external_clock_pin_i, internal_source_clock_i};

    genvar si;
    generate
        for (si = 0; si < 4; si = si + 1)
        begin : g_sync
            ocs_sync2 #(.W(1)) u_sync
            (
                .clk_sys_i (clk_sys_i),
                .rst_i     (rst_i),
                .d_i       (src_raw[si]),
                .q_o       (src_sync[si])
            );
        end
    endgenerate

    // =====================================================
    // configuration capture at reset release
    localparam [1:0] ST_CAPTURE = 2'h0;
    localparam [1:0] ST_RUN     = 2'h1;

    reg  [1:0]                 state_r;
    reg  [1:0]                 state_nxt;
    reg  [1:0]                 sel_nxt;
    wire [`OCS_CFG2_WIDTH-1:0] cfg2_nxt;

    // without a programmed value every bit takes its default
    assign cfg2_nxt = cfg2_valid_i ? cfg2_value_i : `OCS_CFG2_DEFAULT;

    // only one capture per reset so the source never switches live
    always @*
    begin
        state_nxt = state_r;
        sel_nxt   = source_sel_o;
        case (state_r)
            ST_CAPTURE:
            begin
                state_nxt = ST_RUN;
                sel_nxt   = {cfg2_nxt[`OCS_CFG2_SEL_HI], cfg2_nxt[`OCS_CFG2_SEL_LO]};
            end
            ST_RUN:
            begin
                // later configuration changes are ignored until the next reset
                state_nxt = ST_RUN;
            end
            default:
            begin
                // an illegal code keeps the held source instead of recapturing
                state_nxt = ST_RUN;
            end
        endcase
    end

    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_r      <= ST_CAPTURE;
            source_sel_o <= `OCS_SRC_INTERNAL;
        end
        else
        begin
            state_r      <= state_nxt;
            source_sel_o <= sel_nxt;
        end
    end

    // =====================================================
    // source lanes: only the captured source can reach the clock logic
    function lane_hit;
        input [1:0]   sel;
        input integer lane;
        begin
            case (sel)
                `OCS_SRC_INTERNAL: lane_hit = (lane == 0);
                `OCS_SRC_EXTCLK:   lane_hit = (lane == 1);
                `OCS_SRC_RC:       lane_hit = (lane == 2);
                `OCS_SRC_CRYSTAL:  lane_hit = (lane == 3);
                default:           lane_hit = (lane == 0);
            endcase
        end
    endfunction

    // stop gates the source; wait and break deliberately have no effect
    wire       run_w;
    wire [3:0] lane_w;
    wire       src_w;

    assign run_w = (state_r == ST_RUN) & ~stop_mode_i;

    genvar li;
    generate
        for (li = 0; li < 4; li = li + 1)
        begin : g_lane
            // a stopped or unselected lane stays low
            assign lane_w[li] = src_sync[li] & lane_hit(source_sel_o, li) & run_w;
        end
    endgenerate

    assign src_w = |lane_w;

    // =====================================================
    // source edge tracking and bus-rate divider
    reg        src_d_r;
    reg  [1:0] div_r;
    reg  [1:0] div_nxt;
    wire       src_rise;

    // the divider only moves on source edges, so it freezes with the clocks in stop
    assign src_rise = src_w & ~src_d_r;

    always @*
    begin
        div_nxt = div_r;
        if (src_rise)
        begin
            div_nxt = div_r + 2'h1;
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            src_d_r <= 1'b0;
            div_r   <= 2'h0;
        end
        else
        begin
            src_d_r <= src_w;
            div_r   <= div_nxt;
        end
    end

    // =====================================================
    // output clocks, all taken straight from flip-flops
    reg quad_nxt;
    reg half_nxt;
    reg bus_en_nxt;

    // quad-rate follows the source level; half-rate and the bus enable step
    // only on its rising edges, so the three stay in phase
    always @*
    begin
        quad_nxt   = src_w;
        half_nxt   = half_rate_clock_o;
        bus_en_nxt = 1'b0;
        if (src_rise)
        begin
            // half-rate toggles every quad-rate rising edge
            half_nxt   = ~half_rate_clock_o;
            // one bus enable per four quad-rate rising edges
            bus_en_nxt = (div_r == 2'h3);
        end
    end

    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            quad_rate_clock_o <= 1'b0;
            half_rate_clock_o <= 1'b0;
            bus_clock_en_o    <= 1'b0;
        end
        else
        begin
            quad_rate_clock_o <= quad_nxt;
            half_rate_clock_o <= half_nxt;
            bus_clock_en_o    <= bus_en_nxt;
        end
    end

    // =====================================================
    // run status for the sink
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            source_run_o <= 1'b0;
        end
        else
        begin
            source_run_o <= run_w;
        end
    end
endmodule

// [core/ocs_consts.vh]
// constants for the oscillator clock-source select block
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH
// =====================================================
// source select encodings {source_select_hi, source_select_lo}
`define OCS_SRC_INTERNAL 2'h0
`define OCS_SRC_EXTCLK   2'h1
`define OCS_SRC_RC       2'h2
`define OCS_SRC_CRYSTAL  2'h3
// =====================================================
// second configuration register layout and default
`define OCS_CFG2_WIDTH   8
`define OCS_CFG2_SEL_LO  0
`define OCS_CFG2_SEL_HI  1
`define OCS_CFG2_DEFAULT 8'h00
// =====================================================
// divider ratios
`define OCS_HALF_DIV     2
`define OCS_BUS_DIV      4
`endif

// [core/ocs_sync2.v]
// two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module ocs_sync2
#(
    parameter W = 1
)
(
    // clock and reset
    input  wire         clk_sys_i,
    input  wire         rst_i,
    // data
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    // first stage feeds only the second stage
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end
    assign q_o = sync_r;
endmodule

// [bench/ocs_chk_checker.sv]
// port assertions for the clock-source select block
`timescale 1ns/10ps
module ocs_chk (
    input logic       clk_sys_i, rst_i, cfg2_valid_i, stop_mode_i,
    input logic [7:0] cfg2_value_i,
    input logic [1:0] source_sel_o,
    input logic       quad_rate_clock_o, half_rate_clock_o, bus_clock_en_o, source_run_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence rel_s; $fell(rst_i); endsequence
    def_sel_a: assert property (rel_s ##0 !cfg2_valid_i |=> source_sel_o == 2'h0)
        else $error("bad default");
    sel_map_a: assert property (rel_s ##0 cfg2_valid_i |=> source_sel_o == $past(cfg2_value_i[1:0]))
        else $error("bad map");
    sel_hold_a: assert property (!$past(rst_i, 2) |-> $stable(source_sel_o))
        else $error("source moved");
    stop_quiet_a: assert property (stop_mode_i [*8] |-> !quad_rate_clock_o && $stable(half_rate_clock_o))
        else $error("clock in stop");
    run_flag_a: assert property (stop_mode_i |=> !source_run_o)
        else $error("run in stop");
    run_on_a: assert property (!$past(stop_mode_i) && !$past(rst_i, 2) |-> source_run_o)
        else $error("run low");
    half_tog_a: assert property ($changed(half_rate_clock_o) |-> $rose(quad_rate_clock_o))
        else $error("half alone");
    bus_en_a: assert property (bus_clock_en_o |-> $rose(quad_rate_clock_o) && !half_rate_clock_o ##1 !bus_clock_en_o)
        else $error("bus enable");
endmodule
bind ocs_clock_select ocs_chk ocs_chk_inst (.*);

// [bench/ocs_sink.sv]
// sink model of the bus-clock logic: counts the clocks it receives
`timescale 1ns/10ps
module ocs_sink (
    input  logic        clk_sys_i, rst_i, quad_i, half_i, bus_en_i,
    output logic [15:0] quad_n_o, half_n_o, bus_n_o
);
    logic q_r, h_r;
    always @(posedge clk_sys_i)
    begin
        q_r <= quad_i;
        h_r <= half_i;
        quad_n_o <= rst_i ? 16'h0 : quad_n_o + {15'h0, quad_i & ~q_r};
        half_n_o <= rst_i ? 16'h0 : half_n_o + {15'h0, half_i ^ h_r};
        bus_n_o <= rst_i ? 16'h0 : bus_n_o + {15'h0, bus_en_i};
    end
endmodule

// [bench/ocs_clock_select_test.sv]
// bench for the clock-source select block
`timescale 1ns/10ps
module ocs_clock_select_test;
    logic        clk_sys_i = 0, rst_i = 1, cfg2_valid_i = 0, stop_mode_i = 0, wait_mode_i = 0, break_state_i = 0;
    logic [7:0]  cfg2_value_i = 8'h00, cnt = 8'h00;
    logic [1:0]  source_sel_o;
    logic        quad_rate_clock_o, half_rate_clock_o, bus_clock_en_o, source_run_o;
    logic [15:0] qn, hn, bn, qs;
    int          bad_count = 0, total_checks = 0, cyc = 0;
    // distinct rates so a wrong source shows in the counts
    wire internal_source_clock_i = cnt[2], external_clock_pin_i = cnt[3];
    wire rc_source_clock_i = cnt[4], crystal_source_clock_i = cnt[5];
    ocs_clock_select ocs_clock_select_inst (.*);
    ocs_sink ocs_sink_inst (.clk_sys_i, .rst_i, .quad_i(quad_rate_clock_o), .half_i(half_rate_clock_o),
        .bus_en_i(bus_clock_en_o), .quad_n_o(qn), .half_n_o(hn), .bus_n_o(bn));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
    begin
        cnt <= cnt + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            test_done;
        end
    end
    task automatic check(input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input logic v, input logic [7:0] val);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        stop_mode_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        {cfg2_valid_i, cfg2_value_i, rst_i} <= {v, val, 1'b0};
        repeat (2) @(posedge clk_sys_i);
    endtask
    task automatic test_default;
        do_reset(1'b0, 8'h03);
        #1 check({14'h0, source_sel_o}, 16'h0);
        $display("default done");
    endtask
    task automatic test_select(input logic [1:0] s);
        logic [15:0] e;
        e = 16'h100 >> (s + 3);
        do_reset(1'b1, {6'h00, s});
        {wait_mode_i, break_state_i} <= 2'h3;
        repeat (256) @(posedge clk_sys_i);
        #1 check({15'h0, source_run_o}, 16'h1);
        @(posedge clk_sys_i);
        stop_mode_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        {cfg2_valid_i, cfg2_value_i} <= ~{cfg2_valid_i, cfg2_value_i};
        qs <= qn;
        repeat (32) @(posedge clk_sys_i);
        #1 check({14'h0, source_sel_o}, {14'h0, s});
        check(qn, qs);
        check({14'h0, source_run_o, quad_rate_clock_o}, 16'h0);
        check(hn, qn);
        check(bn, qn >> 2);
        check({15'h0, qn + 16'h1 >= e && qn <= e + 16'h1}, 16'h1);
        $display("select %0d done", s);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        test_default;
        for (int i = 0; i < 4; i++)
            test_select(i[1:0]);
        test_done;
    end
endmodule
